// [src/cache_mode_pkg.sv]
// constants for the secondary cache mode control block
package cache_mode_pkg;
    // register map (byte addresses on apb)
    localparam logic [7:0] addr_cache_mode_control = 8'h20;
    localparam logic [7:0] addr_cache_status = 8'h24;
    // field positions of the mode register
    localparam int pos_wrmode = 0;
    localparam int pos_initcache = 1;
    localparam int pos_frzcdir = 2;
    localparam int pos_enable = 3;
    // reset and recommended values
    localparam logic [7:0] mode_reset = 8'h00;
    localparam logic [7:0] mode_dual_wb = 8'h09;
    localparam logic [7:0] mode_init = 8'h03;
    // apb slave answers in the access phase with no wait state
    localparam int apb_wait_cycles = 0;
endpackage

// [src/cache_policy_decode.sv]
// decodes the mode bits into per-cycle cache actions
`timescale 1ns/1ps
module cache_policy_decode
(
    // mode bits
    input wire logic enable,
    input wire logic initcache,
    input wire logic wrmode,
    input wire logic frzcdir,
    // current memory cycle
    input wire logic cyc_valid,
    input wire logic cyc_write,
    input wire logic cyc_cacheable,
    input wire logic cyc_hit,
    input wire logic cyc_dirty,
    // decided actions
    output logic serve_read_hit,
    output logic line_fill,
    output logic castout,
    output logic write_back,
    output logic write_through,
    output logic tag_update
);
    logic act;
    logic rd;
    logic wr;

    // common qualifiers; an initialization pass fills lines while the cache is still disabled
    assign act = cyc_valid && cyc_cacheable && (enable || initcache);
    assign rd = act && !cyc_write;
    assign wr = act && cyc_write;

    // read path
    assign serve_read_hit = rd && cyc_hit && !initcache;
    assign line_fill = rd && (initcache || !cyc_hit);
    assign castout = rd && !cyc_hit && cyc_dirty && !initcache;
    // write hit policy, wrmode ignored while initializing
    assign write_back = wr && cyc_hit && wrmode && !initcache;
    assign write_through = wr && cyc_hit && (!wrmode || initcache);
    // directory update blocked by freeze
    assign tag_update = line_fill && !frzcdir;
endmodule

// [src/secondary_cache_mode_control.sv]
// secondary cache mode register with apb access and cycle policy outputs
`timescale 1ns/1ps
module secondary_cache_mode_control
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory cycle from processor or local bus
    input wire logic cyc_valid,
    input wire logic cyc_write,
    input wire logic cyc_cacheable,
    input wire logic cyc_hit,
    input wire logic cyc_dirty,
    // cache actions
    output logic serve_read_hit,
    output logic line_fill,
    output logic castout,
    output logic write_back,
    output logic write_through,
    output logic tag_update,
    // software order violation seen
    output logic order_error
);
    // ==========================================
    // state
    typedef struct packed {
        logic [7:0] mode;
        logic [31:0] rdata;
        logic slverr;
        logic viol;
    } state_t;

    state_t st;
    state_t next_st;
    logic [1:0] rst_sync;
    logic rst_n_int;
    logic access;
    logic wr_mode;
    logic [7:0] wval;

    // ==========================================
    // reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n_int = rst_sync[1];

    // ==========================================
    // apb decode; zero wait states
    assign access = psel && penable;
    assign wr_mode = access && pwrite && pstrb[0] && (paddr == cache_mode_pkg::addr_cache_mode_control);
    assign wval = pwdata[7:0];
    assign pready = 1'b1;
    assign prdata = st.rdata;
    assign pslverr = st.slverr;
    assign order_error = st.viol;

    // next state
    always_comb
    begin
        next_st = st;
        next_st.slverr = 1'b0;
        if (wr_mode)
        begin
            next_st.mode = wval;
            // flag writes that break the documented programming order
            if ((st.mode[cache_mode_pkg::pos_enable] && wval[cache_mode_pkg::pos_enable]
                    && (wval[cache_mode_pkg::pos_wrmode] != st.mode[cache_mode_pkg::pos_wrmode]))
                || (!st.mode[cache_mode_pkg::pos_initcache] && wval[cache_mode_pkg::pos_initcache]
                    && wval[cache_mode_pkg::pos_enable])
                || (!st.mode[cache_mode_pkg::pos_enable] && wval[cache_mode_pkg::pos_enable]
                    && wval[cache_mode_pkg::pos_initcache]))
                next_st.viol = 1'b1;
        end
        // read data loaded in the setup cycle so it stands through the whole access phase
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                cache_mode_pkg::addr_cache_mode_control: next_st.rdata = {24'h000000, st.mode};
                cache_mode_pkg::addr_cache_status: next_st.rdata = {31'h00000000, st.viol};
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        // clear violation flag by reading status; a new violation wins
        if (access && !pwrite && paddr == cache_mode_pkg::addr_cache_status && !wr_mode)
            next_st.viol = 1'b0;
        if (psel && !penable && paddr != cache_mode_pkg::addr_cache_mode_control
            && paddr != cache_mode_pkg::addr_cache_status)
            next_st.slverr = 1'b1;
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            st.mode <= cache_mode_pkg::mode_reset;
            st.rdata <= 32'h00000000;
            st.slverr <= 1'b0;
            st.viol <= 1'b0;
        end
        else
            st <= next_st;
    end

    // ==========================================
    // cycle policy
    // pure decode; the mode bits come straight from the register
    cache_policy_decode cache_policy_decode_inst
    (
        .enable(st.mode[cache_mode_pkg::pos_enable]),
        .initcache(st.mode[cache_mode_pkg::pos_initcache]),
        .wrmode(st.mode[cache_mode_pkg::pos_wrmode]),
        .frzcdir(st.mode[cache_mode_pkg::pos_frzcdir]),
        .cyc_valid(cyc_valid),
        .cyc_write(cyc_write),
        .cyc_cacheable(cyc_cacheable),
        .cyc_hit(cyc_hit),
        .cyc_dirty(cyc_dirty),
        .serve_read_hit(serve_read_hit),
        .line_fill(line_fill),
        .castout(castout),
        .write_back(write_back),
        .write_through(write_through),
        .tag_update(tag_update)
    );

    // ==========================================
    // assertions
    // reset and register access
    mode_reset_a: assert property (@(posedge clk_sys)
        $rose(rst_n_int) |-> st.mode == cache_mode_pkg::mode_reset)
        else $error("mode not zero after reset");
    readback_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        wr_mode |=> st.mode == $past(wval))
        else $error("mode write lost");
    read_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        access && !pwrite && paddr == cache_mode_pkg::addr_cache_mode_control
        |-> prdata == {24'h000000, st.mode})
        else $error("mode read data wrong");
    strobe_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        access && !wr_mode |=> $stable(st.mode))
        else $error("mode changed without a write");
    ready_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        psel && penable |-> pready)
        else $error("access not ready");
    unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        psel && !penable && paddr != cache_mode_pkg::addr_cache_mode_control
        && paddr != cache_mode_pkg::addr_cache_status |=> pslverr)
        else $error("unmapped access not refused");
    // cycle policy checks
    policy_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        write_back |-> st.mode[0] && !write_through)
        else $error("write back without wrmode");
    hit_policy_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        cyc_valid && cyc_cacheable && cyc_write && cyc_hit && st.mode[3] && !st.mode[1]
        |-> (write_back == st.mode[0]) && (write_through == !st.mode[0]))
        else $error("write hit policy wrong");
    init_fill_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        st.mode[1] && cyc_valid && cyc_cacheable && !cyc_write |-> line_fill && !castout)
        else $error("init read did not fill");
    init_castout_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        castout |-> st.mode[3] && !st.mode[1] && cyc_dirty && !cyc_hit && !cyc_write)
        else $error("castout out of place");
    init_wt_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        st.mode[1] && cyc_valid && cyc_cacheable && cyc_write && cyc_hit
        |-> write_through && !write_back)
        else $error("init write hit not write through");
    init_nowb_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        st.mode[1] |-> !write_back)
        else $error("wrmode acted during init");
    read_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        serve_read_hit |-> !st.mode[1] && cyc_hit && !cyc_write)
        else $error("read hit served while init");
    freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        st.mode[2] |-> !tag_update)
        else $error("tag update while frozen");
    fill_tag_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        line_fill && !st.mode[2] |-> tag_update)
        else $error("fill without tag update");
    disabled_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        !st.mode[3] |-> !(serve_read_hit || write_back || castout)
        && (st.mode[1] || !(line_fill || write_through)))
        else $error("cache acted while disabled");
    // software order checks
    wp_change_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        wr_mode && st.mode[3] && wval[3] && (wval[0] != st.mode[0]) |=> order_error)
        else $error("policy change while enabled not flagged");
    init_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
        wr_mode && wval[1] && wval[3] && !(st.mode[1] && st.mode[3]) |=> order_error)
        else $error("init with enable not flagged");

    // ==========================================
    // cover properties
    wb_cov: cover property (@(posedge clk_sys) write_back);
    init_cov: cover property (@(posedge clk_sys) st.mode == cache_mode_pkg::mode_init ##1 line_fill);
    frz_cov: cover property (@(posedge clk_sys) st.mode[2] && cyc_valid);
    viol_cov: cover property (@(posedge clk_sys) disable iff (!rst_n_int) !order_error ##1 order_error);
    slverr_cov: cover property (@(posedge clk_sys) psel && penable && pslverr);
endmodule

// [sim/cycle_source.sv]
// memory cycle source standing in for the processor and local bus masters
`timescale 1ns/1ps
module cycle_source
(
    // clock
    input wire logic clk_sys,
    // memory cycle
    output logic cyc_valid,
    output logic cyc_write,
    output logic cyc_cacheable,
    output logic cyc_hit,
    output logic cyc_dirty
);
    // bus idle at time zero
    initial
    begin
        cyc_valid = 1'b0;
        {cyc_write, cyc_cacheable, cyc_hit, cyc_dirty} = 4'h0;
    end
    // one cycle per call, launched just after an edge and held until the next call
    task issue(input logic [3:0] c);
    begin
        @(posedge clk_sys);
        cyc_valid <= 1'b1;
        {cyc_write, cyc_cacheable, cyc_hit, cyc_dirty} <= c;
    end
    endtask
endmodule

// [sim/secondary_cache_mode_control_tb.sv]
// self-checking bench for the secondary cache mode control block
`timescale 1ns/1ps
module secondary_cache_mode_control_tb;
    logic clk_sys, rstn, psel, penable, pwrite, pslverr, pready, order_error;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] act;
    logic [3:0] pstrb;
    logic err;
    logic cyc_valid, cyc_write, cyc_cacheable, cyc_hit, cyc_dirty;
    int miscompares = 0;
    int check_count = 0;
    // ======================================================
    // clock, design and cycle source
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    secondary_cache_mode_control secondary_cache_mode_control_inst (.clk_sys(clk_sys), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_write(cyc_write),
        .cyc_cacheable(cyc_cacheable), .cyc_hit(cyc_hit), .cyc_dirty(cyc_dirty),
        .serve_read_hit(act[5]), .line_fill(act[4]), .castout(act[3]), .write_back(act[2]),
        .write_through(act[1]), .tag_update(act[0]), .order_error(order_error));
    cycle_source cycle_source_inst (.clk_sys(clk_sys), .cyc_valid(cyc_valid), .cyc_write(cyc_write),
        .cyc_cacheable(cyc_cacheable), .cyc_hit(cyc_hit), .cyc_dirty(cyc_dirty));
    // ======================================================
    // helpers
    task final_report;
    begin
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // apb transfer: setup, access held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
    begin
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1)
        begin
            miscompares++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    // one memory cycle {write, cacheable, hit, dirty}, masked action compare
    task cyc(input logic [3:0] c, input logic [5:0] e, input logic [5:0] m);
    begin
        cycle_source_inst.issue(c);
        #2 check({26'h0, act & m}, {26'h0, e & m});
    end
    endtask
    // ======================================================
    // main sequence
    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b0, 3'h0, 8'h00, 32'h0, 4'hf};
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        cyc(4'h6, 6'h00, 6'h20);
        apb(1'b1, 8'h20, 32'h03);
        cyc(4'h6, 6'h10, 6'h38);
        cyc(4'h5, 6'h10, 6'h18);
        cyc(4'he, 6'h02, 6'h06);
        apb(1'b1, 8'h20, 32'h02);
        cyc(4'he, 6'h02, 6'h06);
        apb(1'b1, 8'h20, 32'h08);
        cyc(4'h6, 6'h20, 6'h20);
        cyc(4'he, 6'h02, 6'h06);
        apb(1'b1, 8'h20, 32'h00);
        apb(1'b1, 8'h20, 32'h09);
        cyc(4'he, 6'h04, 6'h06);
        cyc(4'h5, 6'h19, 6'h19);
        apb(1'b1, 8'h40, 32'h00);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h09);
        apb(1'b1, 8'h20, 32'h0d);
        cyc(4'h4, 6'h00, 6'h01);
        check({31'h0, order_error}, 32'h0);
        apb(1'b1, 8'h20, 32'h0c);
        #2 check({31'h0, order_error}, 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        check(rd, 32'h1);
        check({31'h0, err}, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        check(rd, 32'h0);
        pstrb <= 4'he;
        apb(1'b1, 8'h20, 32'h00);
        pstrb <= 4'hf;
        apb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0c);
        final_report();
    end
endmodule
